/* rtl/clock_output_config.sv */
// Configuration register bank for six clock output channels, AHB-Lite slave.
// Assumes it is the only slave, so hready is its own hreadyout, and word-sized
// single transfers only.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.

// What this block does
// - Reset and soft reset load all defaults
// - Channel 0 bit 17 write triggers soft reset
// - Channel 1 bit 17 is device power-down
// - Per-channel power-down; channels 0,1,2,5 default down
// - Channels 3,4 bit 30 select reference oscillator
// - Bits 29:28 add analog delay, default none
// - Digital delay bits 27:18, half step bit 16
module clock_output_config (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   output      clock_output_cfg_pkg::channel_ctrl_type   [5:0] channel_settings,
   output      clock_output_cfg_pkg::channel_enable_type [5:0] channel_enables,
   output      logic        device_power_down
);

   localparam int N = clock_output_cfg_pkg::CHANNELS;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic clock_output_cfg_pkg::channel_ctrl_type channel_default(input int ch);
      clock_output_cfg_pkg::channel_ctrl_type c;
      c.power_down          = clock_output_cfg_pkg::PD_DEFAULT[ch];
      c.source_select       = clock_output_cfg_pkg::SRC_DEFAULT[ch];
      c.analog_delay_select = clock_output_cfg_pkg::ADLY_DEFAULT;
      c.digital_delay_count = clock_output_cfg_pkg::DDLY_DEFAULT;
      c.delay_half_step     = clock_output_cfg_pkg::HS_DEFAULT;
      return c;
   endfunction : channel_default

   // Channel word as software sees it; used by the bus read and by readback
   function automatic logic [31:0] channel_word(
      input clock_output_cfg_pkg::channel_ctrl_type c,
      input logic                                  with_src,
      input logic                                  with_dev_pd,
      input logic                                  dev_pd
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      w[clock_output_cfg_pkg::POS_PD]  = c.power_down;
      w[clock_output_cfg_pkg::POS_SRC] = with_src & c.source_select;
      w[clock_output_cfg_pkg::POS_ADLY_LO +: 2] = c.analog_delay_select;
      w[clock_output_cfg_pkg::POS_DDLY_LO +: clock_output_cfg_pkg::DDLY_WIDTH] =
         c.digital_delay_count;
      w[clock_output_cfg_pkg::POS_DEV_PD] = with_dev_pd & dev_pd;
      w[clock_output_cfg_pkg::POS_HS]  = c.delay_half_step;
      return w;
   endfunction : channel_word

   // ----------------------------------------------------------------
   // Bus phase tracking
   // ----------------------------------------------------------------
   logic                                   phase_valid_q;
   logic                                   phase_write_q;
   logic                                   phase_mapped_q;
   logic [5:0]                             phase_idx_q;
   logic                                   rd_wait_q;
   logic [31:0]                            hrdata_q;
   logic                                   accept;
   logic                                   wr_en;
   logic                                   wr_cfg;
   logic                                   soft_reset;

   clock_output_cfg_pkg::channel_ctrl_type [5:0] ctrl_q;
   logic                                   dev_pd_q;
   logic                                   rb_le_q;
   logic [4:0]                             rb_addr_q;
   logic                                   lock_q;
   logic [26:0]                            rb_data_q;
   logic [26:0]                            rb_live;
   logic [31:0]                            read_word;

   assign accept = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_valid_q  <= 1'b0;
         phase_write_q  <= 1'b0;
         phase_mapped_q <= 1'b0;
         phase_idx_q    <= 6'h00;
      end else if (hready) begin
         phase_valid_q  <= accept;
         phase_write_q  <= hwrite;
         phase_mapped_q <= (haddr[31:clock_output_cfg_pkg::ADDR_HI_LSB] == 24'h00_0000);
         phase_idx_q    <= haddr[clock_output_cfg_pkg::IDX_LSB +: clock_output_cfg_pkg::IDX_WIDTH];
      end
   end

   // Reads take one wait state so a write just before is already visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_q <= 1'b0;
      end else if (hready) begin
         rd_wait_q <= accept & ~hwrite;
      end else begin
         rd_wait_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_wait_q) begin
         hrdata_q <= read_word;
      end
   end

   assign hreadyout = ~rd_wait_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_en  = phase_valid_q & phase_write_q & phase_mapped_q & hready;
   // Locked bank ignores everything but the lock register itself
   assign wr_cfg = wr_en & ~lock_q & (phase_idx_q < 6'(N));
   assign soft_reset = wr_cfg & (phase_idx_q == clock_output_cfg_pkg::IDX_CHANNEL0)
                     & hwdata[clock_output_cfg_pkg::POS_RESET];

   // ----------------------------------------------------------------
   // Channel control registers
   // ----------------------------------------------------------------
   // Soft reset bit is not stored, so it always reads back as not in reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < N; i++) begin
            ctrl_q[i] <= channel_default(i);
         end
      end else if (soft_reset) begin
         for (int i = 0; i < N; i++) begin
            ctrl_q[i] <= channel_default(i);
         end
      end else if (wr_cfg) begin
         for (int i = 0; i < N; i++) begin
            if (phase_idx_q == 6'(i)) begin
               ctrl_q[i].power_down <= hwdata[clock_output_cfg_pkg::POS_PD];
               ctrl_q[i].source_select <= clock_output_cfg_pkg::SRC_PRESENT[i]
                  & hwdata[clock_output_cfg_pkg::POS_SRC];
               ctrl_q[i].analog_delay_select <=
                  hwdata[clock_output_cfg_pkg::POS_ADLY_LO +: 2];
               ctrl_q[i].digital_delay_count <=
                  hwdata[clock_output_cfg_pkg::POS_DDLY_LO +:
                         clock_output_cfg_pkg::DDLY_WIDTH];
               ctrl_q[i].delay_half_step <= hwdata[clock_output_cfg_pkg::POS_HS];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dev_pd_q <= clock_output_cfg_pkg::DEV_PD_DEFAULT;
      end else if (soft_reset) begin
         dev_pd_q <= clock_output_cfg_pkg::DEV_PD_DEFAULT;
      end else if (wr_cfg && phase_idx_q == 6'h01) begin
         dev_pd_q <= hwdata[clock_output_cfg_pkg::POS_DEV_PD];
      end
   end

   // ----------------------------------------------------------------
   // Readback select and lock register
   // ----------------------------------------------------------------
   // Always writable, otherwise a locked bank could never be unlocked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rb_le_q   <= 1'b0;
         rb_addr_q <= clock_output_cfg_pkg::RB_ADDR_DEFAULT;
         lock_q    <= 1'b0;
      end else if (soft_reset) begin
         rb_le_q   <= 1'b0;
         rb_addr_q <= clock_output_cfg_pkg::RB_ADDR_DEFAULT;
         lock_q    <= 1'b0;
      end else if (wr_en && phase_idx_q == clock_output_cfg_pkg::IDX_LOCK) begin
         rb_le_q   <= hwdata[clock_output_cfg_pkg::POS_RB_LE];
         rb_addr_q <= hwdata[clock_output_cfg_pkg::POS_RB_ADDR +: 5];
         lock_q    <= hwdata[clock_output_cfg_pkg::POS_LOCK];
      end
   end

   // ----------------------------------------------------------------
   // Readback data
   // ----------------------------------------------------------------
   always_comb begin
      rb_live = 27'h000_0000;
      for (int i = 0; i < N; i++) begin
         if (rb_addr_q == 5'(i)) begin
            rb_live = 27'(channel_word(ctrl_q[i], clock_output_cfg_pkg::SRC_PRESENT[i],
               (i == 1), dev_pd_q) >> clock_output_cfg_pkg::RB_SHIFT);
         end
      end
      if (rb_addr_q == clock_output_cfg_pkg::IDX_LOCK[4:0]) begin
         rb_live = {26'h000_0000, lock_q};
      end
   end

   // Latch enable freezes the captured word so software can read a stable image
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rb_data_q <= 27'h000_0000;
      end else if (!rb_le_q) begin
         rb_data_q <= rb_live;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      read_word = 32'h0000_0000;
      if (phase_mapped_q) begin
         for (int i = 0; i < N; i++) begin
            if (phase_idx_q == 6'(i)) begin
               read_word = channel_word(ctrl_q[i], clock_output_cfg_pkg::SRC_PRESENT[i],
                                        (i == 1), dev_pd_q);
            end
         end
         if (phase_idx_q == clock_output_cfg_pkg::IDX_LOCK) begin
            read_word = 32'h0000_0000;
            read_word[clock_output_cfg_pkg::POS_RB_LE] = rb_le_q;
            read_word[clock_output_cfg_pkg::POS_RB_ADDR +: 5] = rb_addr_q;
            read_word[clock_output_cfg_pkg::POS_LOCK] = lock_q;
         end
         if (phase_idx_q == clock_output_cfg_pkg::IDX_READBACK) begin
            read_word = {5'h00, rb_data_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel outputs
   // ----------------------------------------------------------------
   assign channel_settings  = ctrl_q;
   assign device_power_down = dev_pd_q;

   for (genvar g = 0; g < N; g++) begin : g_channel
      channel_output_gate #(
         .HAS_SOURCE_SELECT (clock_output_cfg_pkg::SRC_PRESENT[g])
      ) u_gate (
         .hclk              (hclk),
         .hresetn           (hresetn),
         .ctrl              (ctrl_q[g]),
         .device_power_down (dev_pd_q),
         .enables           (channel_enables[g])
      );
   end

endmodule : clock_output_config

/* common/clock_output_cfg_pkg.sv */
// Constants, field layout and carrier types for the clock output configuration bank.
// Assumes a single AHB-Lite slave with 32-bit data and word-aligned registers.
package clock_output_cfg_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int          CHANNELS      = 6;
   localparam int          DDLY_WIDTH    = 10;
   localparam int          RB_WIDTH      = 27;
   localparam int          IDX_WIDTH     = 6;

   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [5:0]  IDX_CHANNEL0  = 6'h00;
   localparam logic [5:0]  IDX_LOCK      = 6'h1f;
   localparam logic [5:0]  IDX_READBACK  = 6'h20;
   localparam int          IDX_LSB       = 2;
   localparam int          ADDR_HI_LSB   = 8;

   // ----------------------------------------------------------------
   // Field positions in a channel control word
   // ----------------------------------------------------------------
   localparam int          POS_PD        = 31;
   localparam int          POS_SRC       = 30;
   localparam int          POS_ADLY_LO   = 28;
   localparam int          POS_DDLY_LO   = 18;
   localparam int          POS_RESET     = 17;
   localparam int          POS_DEV_PD    = 17;
   localparam int          POS_HS        = 16;
   localparam int          RB_SHIFT      = 5;

   // ----------------------------------------------------------------
   // Field positions in the readback select and lock word
   // ----------------------------------------------------------------
   localparam int          POS_RB_LE     = 21;
   localparam int          POS_RB_ADDR   = 16;
   localparam int          POS_LOCK      = 0;

   // ----------------------------------------------------------------
   // Reset values and channel masks; the 6-bit ones hold one bit per channel
   // ----------------------------------------------------------------
   localparam logic [5:0]  PD_DEFAULT    = 6'h27;
   localparam logic [5:0]  SRC_DEFAULT   = 6'h08;
   localparam logic [5:0]  SRC_PRESENT   = 6'h18;
   localparam logic [1:0]  ADLY_DEFAULT  = 2'h0;
   localparam logic [9:0]  DDLY_DEFAULT  = 10'h000;
   localparam logic        HS_DEFAULT    = 1'b0;
   localparam logic        DEV_PD_DEFAULT = 1'b0;
   localparam logic [4:0]  RB_ADDR_DEFAULT = 5'h00;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       power_down;
      logic       source_select;
      logic [1:0] analog_delay_select;
      logic [9:0] digital_delay_count;
      logic       delay_half_step;
   } channel_ctrl_type;

   typedef struct packed {
      logic        analog_delay_en;
      logic        digital_delay_en;
      logic        divider_en;
      logic        buffer_a_en;
      logic        buffer_b_en;
      logic        use_reference_osc;
      logic [10:0] delay_half_steps;
   } channel_enable_type;

endpackage : clock_output_cfg_pkg

/* rtl/channel_output_gate.sv */
// Per-channel enable decode for one clock output.
// Assumes its control word and the device power-down come from flops on hclk.
module channel_output_gate #(
   parameter logic HAS_SOURCE_SELECT = 1'b0
) (
   input  wire logic                                  hclk,
   input  wire logic                                  hresetn,
   input  wire clock_output_cfg_pkg::channel_ctrl_type ctrl,
   input  wire logic                                  device_power_down,
   output      clock_output_cfg_pkg::channel_enable_type enables
);

   logic active;

   // ----------------------------------------------------------------
   // Enable decode
   // ----------------------------------------------------------------
   assign active = ~ctrl.power_down & ~device_power_down;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enables <= '0;
      end else begin
         enables.analog_delay_en   <= active & (|ctrl.analog_delay_select);
         enables.digital_delay_en  <= active;
         enables.divider_en        <= active;
         enables.buffer_a_en       <= active;
         enables.buffer_b_en       <= active;
         // Channels without a selector always run from the internal oscillator
         enables.use_reference_osc <= HAS_SOURCE_SELECT & ctrl.source_select;
         enables.delay_half_steps  <= {ctrl.digital_delay_count,
                                       ctrl.delay_half_step};
      end
   end

endmodule : channel_output_gate

/* testbench/clock_output_config_asserts.sv */
// Concurrent checks for the clock output configuration bank.
// Assumes one hclk domain, bound to every instance of the bank.
module clock_output_config_asserts (
   input wire logic                                            hclk,
   input wire logic                                            hresetn,
   input wire logic                                            hsel,
   input wire logic [1:0]                                      htrans,
   input wire logic                                            hwrite,
   input wire logic                                            hready,
   input wire logic                                            hreadyout,
   input wire logic                                            hresp,
   input wire logic [31:0]                                     hrdata,
   input wire clock_output_cfg_pkg::channel_ctrl_type   [5:0] channel_settings,
   input wire clock_output_cfg_pkg::channel_enable_type [5:0] channel_enables,
   input wire logic                                            device_power_down
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic acc_rd;
   logic acc_wr;
   assign acc_rd = hsel && hready && htrans[1] && !hwrite;
   assign acc_wr = hsel && hready && htrans[1] && hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------------------------------
   // Bus timing
   // ----------------------------------------------------------------
   chk_rd_one_wait: assert property (acc_rd |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   chk_wr_no_wait: assert property (acc_wr |=> hreadyout)
      else $error("write data phase stalled");
   chk_resp_okay: assert property (!hresp)
      else $error("error response seen");
   chk_rdata_load: assert property (!$stable(hrdata) |-> $past(!hreadyout))
      else $error("read data changed outside a read");
   // Settings move only two edges after an accepted write
   chk_settings_hold: assert property (
      !$stable({channel_settings, device_power_down}) |-> $past(acc_wr, 2))
      else $error("settings changed without a write");
   // ----------------------------------------------------------------
   // Channel gating
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 6; k++) begin : g_ch
      chk_pd_gates: assert property (channel_settings[k].power_down |=>
         !channel_enables[k].divider_en && !channel_enables[k].buffer_a_en &&
         !channel_enables[k].buffer_b_en && !channel_enables[k].digital_delay_en &&
         !channel_enables[k].analog_delay_en)
         else $error("powered down channel still enabled");
      chk_on_enables: assert property (
         !channel_settings[k].power_down && !device_power_down |=>
         channel_enables[k].divider_en && channel_enables[k].buffer_a_en)
         else $error("running channel not enabled");
      chk_dev_pd_gates: assert property (device_power_down |=>
         !channel_enables[k].divider_en)
         else $error("device power-down left a divider on");
      chk_steps_follow: assert property (1'b1 |=>
         channel_enables[k].delay_half_steps ==
         $past({channel_settings[k].digital_delay_count, channel_settings[k].delay_half_step}))
         else $error("delay steps not followed");
      if (clock_output_cfg_pkg::SRC_PRESENT[k]) begin : g_src
         chk_src_follow: assert property (
            !channel_settings[k].power_down && !device_power_down |=>
            channel_enables[k].use_reference_osc ==
            $past(channel_settings[k].source_select))
            else $error("source select not followed");
      end
   end
endmodule : clock_output_config_asserts

bind clock_output_config clock_output_config_asserts u_asserts (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .channel_settings(channel_settings), .channel_enables(channel_enables),
   .device_power_down(device_power_down));

/* testbench/ahb_host_model.sv */
// Host side of the bank: a single-transfer AHB-Lite master.
// Assumes hready is the bank's hreadyout; the bench calls write and read.
module ahb_host_model (
   input wire logic        hclk,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   output     logic        hsel,
   output     logic [31:0] haddr,
   output     logic [1:0]  htrans,
   output     logic        hwrite,
   output     logic [2:0]  hsize,
   output     logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Address phase held until taken, then data phase held until ready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      r = hrdata;
      // Released buses show a changed pattern, never the stale value
      hwdata <= ~d;
      haddr <= ~a;
   endtask : xfer
   // Carries channel words, soft reset requests and readback select or lock words
   task automatic write(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : write
   task automatic read(input logic [31:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask : read
endmodule : ahb_host_model

/* testbench/clock_output_config_tb.sv */
// Self-checking bench for the clock output configuration bank.
// Assumes the host model drives the bus and the checker is bound to the bank.
module clock_output_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                                     hclk, hresetn, hsel, hwrite, hready;
   logic                                     hreadyout, hresp, device_power_down, rd_pend;
   logic [31:0]                              haddr, hwdata, hrdata, sh31, seed, rdv, rbf;
   logic [1:0]                               htrans;
   logic [2:0]                               hsize;
   logic [31:0]                              sh [6];
   logic [31:0]                              exp_q [$];
   clock_output_cfg_pkg::channel_ctrl_type   [5:0] channel_settings;
   clock_output_cfg_pkg::channel_enable_type [5:0] channel_enables;
   int                                       n_errors, compares, cyc;
   assign hready = hreadyout;
   initial hclk = 1'b0;
   always #20 hclk = ~hclk;
   clock_output_config u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .channel_settings(channel_settings), .channel_enables(channel_enables),
      .device_power_down(device_power_down));
   ahb_host_model u_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // ----------------------------------------------------------------
   // Shadow model and helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction : lfsr
   function automatic logic [31:0] mask(input int n);
      logic [31:0] m;
      m = 32'hffff_0000;
      m[30] = clock_output_cfg_pkg::SRC_PRESENT[n];
      if (n != 1) m[17] = 1'b0;
      return m;
   endfunction : mask
   function automatic logic [31:0] rb_exp();
      int s;
      s = int'(sh31[20:16]);
      rb_exp = 32'h0;
      if (s < 6) rb_exp = {5'h0, sh[s][31:5]};
      else if (s == 31) rb_exp = {31'h0, sh31[0]};
   endfunction : rb_exp
   task automatic defaults();
      for (int n = 0; n < 6; n++) begin
         sh[n] = {clock_output_cfg_pkg::PD_DEFAULT[n], clock_output_cfg_pkg::SRC_DEFAULT[n],
                  30'h0};
      end
      sh31 = 32'h0;
   endtask : defaults
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int i;
      i = int'(a[7:2]);
      u_host.write(a, d);
      if (a[31:8] == 24'h0 && i == 31) begin
         if (!sh31[21]) rbf = rb_exp();
         sh31 = d & 32'h003f_0001;
      end else if (a[31:8] == 24'h0 && i < 6 && !sh31[0]) begin
         if (i == 0 && d[17]) defaults();
         else sh[i] = d & mask(i);
      end
   endtask : wr
   task automatic rd(input logic [31:0] a);
      int i;
      logic [31:0] e;
      i = int'(a[7:2]);
      e = 32'h0;
      if (a[31:8] == 24'h0) begin
         if (i < 6) e = sh[i];
         else if (i == 31) e = sh31;
         else if (i == 32) e = sh31[21] ? rbf : rb_exp();
      end
      exp_q.push_back(e);
      u_host.read(a, rdv);
   endtask : rd
   task automatic rd_all();
      for (int n = 0; n < 6; n++) rd(32'(4 * n));
      rd(32'h7c);
   endtask : rd_all
   task automatic chk_cfg();
      @(negedge hclk);
      for (int n = 0; n < 6; n++) begin
         check({17'h0, channel_settings[n]}, {17'h0, sh[n][31:18], sh[n][16]});
      end
      check({31'h0, device_power_down}, {31'h0, sh[1][17]});
   endtask : chk_cfg
   task automatic end_of_test();
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // ----------------------------------------------------------------
   // Read monitor and timeout
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      if (rd_pend && hready) begin
         check(hrdata, exp_q.pop_front());
         rd_pend = 1'b0;
      end else if (hsel && hready && htrans[1] && !hwrite) rd_pend = 1'b1;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] sel [8];
      sel = '{32'd0, 32'd1, 32'd2, 32'd3, 32'd4, 32'd5, 32'd31, 32'd12};
      hresetn = 1'b0;
      rd_pend = 1'b0;
      n_errors = 0;
      compares = 0;
      cyc = 0;
      seed = 32'd51;
      defaults();
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk_cfg();
      rd_all();
      // Random words, then delay fields at their top values with power-down and source select clear
      for (int p = 0; p < 2; p++) begin
         for (int n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            wr(32'(4 * n), (p == 1) ? 32'h3ffd_0000 : (seed & 32'hfffd_ffff));
            rd(32'(4 * n));
            chk_cfg();
         end
      end
      wr(32'h4, 32'h3ffe_0000);
      chk_cfg();
      wr(32'h4, 32'h0);
      // Unmapped and read-only places take no write
      foreach (sel[j]) if (j < 4) begin
         wr(j == 0 ? 32'h18 : j == 1 ? 32'h78 : j == 2 ? 32'h100 : 32'h80, 32'hffff_ffff);
         rd(j == 0 ? 32'h18 : j == 1 ? 32'h78 : j == 2 ? 32'h100 : 32'h80);
      end
      foreach (sel[j]) begin
         wr(32'h7c, sel[j] << 16);
         rd(32'h80);
      end
      // Latch enable keeps the captured word while the channel changes
      wr(32'h7c, 32'h0003_0000);
      wr(32'h7c, 32'h0023_0000);
      wr(32'hc, 32'h0);
      rd(32'h80);
      rd(32'h7c);
      wr(32'h7c, 32'h0);
      // Locked bank ignores channel writes and soft reset
      wr(32'h7c, 32'h001f_0001);
      rd(32'h80);
      wr(32'h8, 32'hffff_ffff);
      wr(32'h0, 32'h0002_0000);
      chk_cfg();
      wr(32'h7c, 32'h0);
      wr(32'h0, 32'h8002_0000);
      chk_cfg();
      rd_all();
      wr(32'h14, 32'h0fc4_0000);
      @(posedge hclk);
      hresetn <= 1'b0;
      defaults();
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk_cfg();
      rd_all();
      repeat (4) @(posedge hclk);
      end_of_test();
   end
endmodule : clock_output_config_tb
